// File: verilog/rsgtd_top.sv
// Ringing waveform shaper and ring trip detection top level.
// How it works
// [RULE1] Half-period counts 8 kHz samples; amplitude full scale 2^15 is 96 V peak.
// [RULE2] Each sample the ramp step is added or subtracted from the waveform.
// [RULE3] Waveform clamps at plus/minus amplitude; direction flips when half-period expires.
// [RULE4] Wave select one gives trapezoid, zero gives the sinusoidal input.
// [RULE5] Dc offset is added only while offset enable is set.
// [RULE6] Software codes offset as volts divided by 96 times 2^15.
// [RULE7] Common-mode level during ringing is (battery minus headroom) halved.
// [RULE8] Headroom is a 4-bit field of 1.5 V per step.
// [RULE9] Boost enable raises current limit briefly when ringing ends into dc feed.
// [RULE10] Trip detection runs only while the line state shows ringing.
// [RULE11] Loop current passes a low-pass filter with a 13-bit coefficient.
// [RULE12] Filtered current compared with a 6-bit threshold gives one bit.
// [RULE13] Debounce changes output only after a full interval of opposite input.
// [RULE14] A satisfied debounce sets the read-only trip status bit.
// [RULE15] Valid trip sets pending flag; interrupt raised only when enabled.
// [RULE16] Software picks filter, threshold and debounce per ringing frequency.
// [RULE17] Detector advances per sample strobe; count clears when comparator agrees.
// [RULE18] Line state code 100 enters ringing and starts the first ring.
// [RULE19] Active timer ends ring; inactive timer restarts it while enabled and ringing.
`timescale 1ns/1ps
`default_nettype none
module rsgtd_top #(
  parameter int unsigned SAMPLE_DIV_P = rsgtd_pkg::SAMPLE_DIV
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [rsgtd_pkg::LINE_STATE_W-1:0] line_state_field,
  input wire logic wave_shape_select,
  input wire logic ring_offset_enable,
  input wire logic [rsgtd_pkg::SAMPLE_W-1:0] ring_amplitude,
  input wire logic [rsgtd_pkg::SAMPLE_W-1:0] ring_phase_or_half_period,
  input wire logic [rsgtd_pkg::SAMPLE_W-1:0] ring_freq_or_ramp_step,
  input wire logic signed [rsgtd_pkg::SAMPLE_W-1:0] ring_dc_offset,
  input wire logic signed [rsgtd_pkg::SAMPLE_W-1:0] sine_sample,
  input wire logic [rsgtd_pkg::HEADROOM_W-1:0] ring_headroom,
  input wire logic [rsgtd_pkg::BATTERY_W-1:0] high_battery_setting,
  input wire logic transition_current_boost_en,
  input wire logic ring_on_timer_en,
  input wire logic ring_off_timer_en,
  input wire logic [rsgtd_pkg::SAMPLE_W-1:0] ring_on_timer,
  input wire logic [rsgtd_pkg::SAMPLE_W-1:0] ring_off_timer,
  input wire logic signed [rsgtd_pkg::SAMPLE_W-1:0] loop_current_sample,
  input wire logic [rsgtd_pkg::FILTER_COEFF_W-1:0] trip_filter_coeff,
  input wire logic [rsgtd_pkg::THRESHOLD_W-1:0] trip_threshold,
  input wire logic [rsgtd_pkg::DEBOUNCE_W-1:0] trip_debounce_interval,
  input wire logic trip_irq_enable,
  input wire logic trip_irq_clear,
  output logic signed [rsgtd_pkg::SAMPLE_W-1:0] ring_wave_out,
  output logic ring_active,
  output logic [rsgtd_pkg::BATTERY_W-1:0] ring_common_mode_level,
  output logic current_boost,
  output logic trip_detected_status,
  output logic trip_irq_pending,
  output logic trip_irq
);
  import rsgtd_pkg::*;

  logic [$clog2(SAMPLE_DIV_P)-1:0] div_q;
  logic sample_en;
  logic ringing;
  logic ringing_q;
  logic [SAMPLE_W-1:0] cad_q;
  logic [SAMPLE_W-1:0] half_q;
  rsgtd_dir_t dir_q;
  logic signed [SAMPLE_W+1:0] wave_next;
  logic signed [SAMPLE_W+1:0] amp_ext;
  logic signed [SAMPLE_W-1:0] trap_q;
  logic signed [SAMPLE_W:0] sum;
  logic [BATTERY_W+1:0] cm_sum;
  logic [$clog2(BOOST_SAMPLES+1)-1:0] boost_q;
  logic trip_out;
  logic trip_event;

  // The 8 kHz strobe; one clock, the strobe is an enable pulse.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= '0;
    end else if (div_q == ($clog2(SAMPLE_DIV_P))'(SAMPLE_DIV_P - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign sample_en = (div_q == ($clog2(SAMPLE_DIV_P))'(SAMPLE_DIV_P - 1));

  assign ringing = (line_state_field == LINE_STATE_RINGING); // RULE18

  // Cadence: count on samples, then off samples, while both timers enabled.
  // With a timer disabled the ring stays on for as long as the state holds.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ringing_q <= 1'b0;
      ring_active <= 1'b0;
      cad_q <= '0;
    end else begin
      ringing_q <= ringing;
      if (!ringing) begin
        ring_active <= 1'b0;
        cad_q <= '0;
      end else if (!ringing_q) begin
        ring_active <= 1'b1; // RULE18
        cad_q <= '0;
      end else if (sample_en && ring_on_timer_en && ring_off_timer_en) begin
        if (ring_active && cad_q + 1'b1 >= ring_on_timer) begin
          ring_active <= 1'b0; // RULE19
          cad_q <= '0;
        end else if (!ring_active && cad_q + 1'b1 >= ring_off_timer) begin
          ring_active <= 1'b1; // RULE19
          cad_q <= '0;
        end else begin
          cad_q <= cad_q + 1'b1;
        end
      end
    end
  end

  // Trapezoid: ramp by the step each sample, clamp at the amplitude,
  // reverse when the half-period count runs out. Restarts from zero.
  assign amp_ext = $signed({2'b00, ring_amplitude});
  assign wave_next = (dir_q == RSGTD_RISE) ?
                     (SAMPLE_W+2)'(trap_q) + $signed({2'b00, ring_freq_or_ramp_step}) :
                     (SAMPLE_W+2)'(trap_q) - $signed({2'b00, ring_freq_or_ramp_step}); // RULE2
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trap_q <= '0;
      half_q <= '0;
      dir_q <= RSGTD_RISE;
    end else if (!ring_active) begin
      trap_q <= '0; // RULE3
      half_q <= '0;
      dir_q <= RSGTD_RISE;
    end else if (sample_en) begin
      if (wave_next > amp_ext) begin
        trap_q <= SAMPLE_W'(amp_ext); // RULE3
      end else if (wave_next < -amp_ext) begin
        trap_q <= SAMPLE_W'(-amp_ext); // RULE3
      end else begin
        trap_q <= SAMPLE_W'(wave_next);
      end
      if (half_q + 1'b1 >= ring_phase_or_half_period) begin
        half_q <= '0; // RULE1
        dir_q <= (dir_q == RSGTD_RISE) ? RSGTD_FALL : RSGTD_RISE; // RULE3
      end else begin
        half_q <= half_q + 1'b1;
      end
    end
  end

  // Shape select and offset, saturated to full scale; the offset code is
  // trusted to follow the 96 V scaling software applies.
  assign sum = (wave_shape_select ? (SAMPLE_W+1)'(trap_q) : (SAMPLE_W+1)'(sine_sample)) +
               (ring_offset_enable ? (SAMPLE_W+1)'(ring_dc_offset) : '0); // RULE4 RULE5 RULE6
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ring_wave_out <= '0;
    end else if (!ring_active) begin
      ring_wave_out <= '0;
    end else if (sum > (SAMPLE_W+1)'(FULL_SCALE_POS)) begin
      ring_wave_out <= FULL_SCALE_POS;
    end else if (sum < (SAMPLE_W+1)'(FULL_SCALE_NEG)) begin
      ring_wave_out <= FULL_SCALE_NEG;
    end else begin
      ring_wave_out <= SAMPLE_W'(sum);
    end
  end

  // Common mode in 1.5 V battery units: battery is 1.5 V/step too, so
  // headroom subtracts directly; floors at zero rather than wrapping.
  assign cm_sum = (high_battery_setting > BATTERY_W'(ring_headroom)) ?
                  (BATTERY_W+2)'(high_battery_setting - BATTERY_W'(ring_headroom)) : '0; // RULE8
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ring_common_mode_level <= '0;
    end else if (ringing) begin
      ring_common_mode_level <= BATTERY_W'(cm_sum >> 1); // RULE7
    end
  end

  // Short current-limit boost when ringing gives way to dc feed.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      boost_q <= '0;
    end else if (ringing_q && !ringing && transition_current_boost_en) begin
      boost_q <= ($clog2(BOOST_SAMPLES+1))'(BOOST_SAMPLES); // RULE9
    end else if (sample_en && boost_q != '0) begin
      boost_q <= boost_q - 1'b1;
    end
  end
  assign current_boost = (boost_q != '0);

  rsgtd_trip_det u_trip (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sample_en(sample_en), // RULE17
    .ringing(ringing), // RULE10
    .loop_current_sample(loop_current_sample), // RULE11
    .trip_filter_coeff(trip_filter_coeff), // RULE16
    .trip_threshold(trip_threshold), // RULE12
    .trip_debounce_interval(trip_debounce_interval), // RULE13
    .trip_out(trip_out),
    .trip_event(trip_event)
  );

  assign trip_detected_status = trip_out; // RULE14

  // Pending flag: a new trip wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trip_irq_pending <= 1'b0;
    end else if (trip_event) begin
      trip_irq_pending <= 1'b1; // RULE15
    end else if (trip_irq_clear) begin
      trip_irq_pending <= 1'b0;
    end
  end
  assign trip_irq = trip_irq_pending & trip_irq_enable; // RULE15
endmodule
`default_nettype wire

// File: verilog/rsgtd_pkg.sv
// Shared constants and types for the ringing shaper and trip detector.
`default_nettype none
package rsgtd_pkg;
  // Sample datapath width; full scale 2^15 equals 96 V peak.
  localparam int unsigned SAMPLE_W = 16;
  localparam logic signed [SAMPLE_W-1:0] FULL_SCALE_POS = 16'sh7fff;
  localparam logic signed [SAMPLE_W-1:0] FULL_SCALE_NEG = -16'sh7fff;
  // Ringing code of the line state field.
  localparam int unsigned LINE_STATE_W = 3;
  localparam logic [LINE_STATE_W-1:0] LINE_STATE_RINGING = 3'h4;
  // Field widths.
  localparam int unsigned HEADROOM_W = 4;
  localparam int unsigned BATTERY_W = 6;
  localparam int unsigned FILTER_COEFF_W = 13;
  localparam int unsigned THRESHOLD_W = 6;
  localparam int unsigned DEBOUNCE_W = 7;
  // Threshold sits in the top bits of the filtered magnitude.
  localparam int unsigned THRESHOLD_LSB = 9;
  // Sample strobe rate derived from the 50 MHz clock.
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned SAMPLE_HZ = 8000;
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  // Boost pulse after leaving ringing, in samples.
  localparam int unsigned BOOST_SAMPLES = 16;
  // Ramp direction of the trapezoid.
  typedef enum logic {RSGTD_RISE, RSGTD_FALL} rsgtd_dir_t;
endpackage
`default_nettype wire

// File: verilog/rsgtd_trip_det.sv
// Ring trip detector: low-pass filter, threshold compare and debounce.
`timescale 1ns/1ps
`default_nettype none
module rsgtd_trip_det (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sample_en,
  input wire logic ringing,
  input wire logic signed [rsgtd_pkg::SAMPLE_W-1:0] loop_current_sample,
  input wire logic [rsgtd_pkg::FILTER_COEFF_W-1:0] trip_filter_coeff,
  input wire logic [rsgtd_pkg::THRESHOLD_W-1:0] trip_threshold,
  input wire logic [rsgtd_pkg::DEBOUNCE_W-1:0] trip_debounce_interval,
  output logic trip_out,
  output logic trip_event
);
  import rsgtd_pkg::*;

  logic signed [SAMPLE_W-1:0] filt_q;
  logic [SAMPLE_W-1:0] mag;
  logic signed [SAMPLE_W+FILTER_COEFF_W:0] prod;
  logic cmp;
  logic [DEBOUNCE_W-1:0] cnt_q;
  logic step;

  // Only samples taken during ringing feed the detector.
  assign step = sample_en & ringing;

  // First-order low-pass: y += coeff * (x - y) / 2^13.
  assign prod = $signed({1'b0, trip_filter_coeff}) *
                (SAMPLE_W+1)'(loop_current_sample - filt_q);
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      filt_q <= '0;
    end else if (step) begin
      filt_q <= filt_q + SAMPLE_W'(prod >>> FILTER_COEFF_W); // RULE11
    end
  end

  // Compare the magnitude's top bits against the threshold.
  assign mag = filt_q[SAMPLE_W-1] ? SAMPLE_W'(-filt_q) : filt_q;
  assign cmp = mag[SAMPLE_W-1:THRESHOLD_LSB] >= {1'b0, trip_threshold}; // RULE12

  // Debounce: output flips only after a full interval of disagreement.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      trip_out <= 1'b0;
      trip_event <= 1'b0;
    end else begin
      trip_event <= 1'b0;
      if (!ringing) begin
        cnt_q <= '0;
        trip_out <= 1'b0;
      end else if (step) begin
        if (cmp == trip_out) begin
          cnt_q <= '0; // RULE17
        end else if (cnt_q + 1'b1 >= trip_debounce_interval) begin
          cnt_q <= '0;
          trip_out <= cmp; // RULE13
          trip_event <= cmp;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: dv/rsgtd_chk.sv
// Port-level assertions for the ringing shaper and trip detector.
`timescale 1ns/1ps
`default_nettype none
module rsgtd_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] line_state_field,
  input wire logic wave_shape_select,
  input wire logic ring_offset_enable,
  input wire logic [15:0] ring_amplitude,
  input wire logic [15:0] ring_freq_or_ramp_step,
  input wire logic signed [15:0] ring_dc_offset,
  input wire logic signed [15:0] sine_sample,
  input wire logic [3:0] ring_headroom,
  input wire logic [5:0] high_battery_setting,
  input wire logic trip_irq_clear,
  input wire logic signed [15:0] ring_wave_out,
  input wire logic ring_active,
  input wire logic [5:0] ring_common_mode_level,
  input wire logic trip_detected_status,
  input wire logic trip_irq_pending
);
  import rsgtd_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Settled trapezoid without offset, so bounds on the output are exact.
  sequence trap_steady;
    ring_active && $past(ring_active) && wave_shape_select && !ring_offset_enable;
  endsequence
  enter_ring_a: assert property ($rose(line_state_field == LINE_STATE_RINGING) |-> ##[1:2] ring_active)
    else $error("ringing did not start");
  leave_ring_a: assert property ((line_state_field != LINE_STATE_RINGING)[*3] |-> !ring_active && !trip_detected_status)
    else $error("active outside ringing");
  amp_clamp_a: assert property (trap_steady |-> ring_wave_out <= $signed({1'b0, ring_amplitude}) && ring_wave_out >= -$signed({1'b0, ring_amplitude}))
    else $error("wave beyond amplitude");
  ramp_step_a: assert property (trap_steady |-> ring_wave_out - $past(ring_wave_out) <= $signed({1'b0, ring_freq_or_ramp_step}) && $past(ring_wave_out) - ring_wave_out <= $signed({1'b0, ring_freq_or_ramp_step}))
    else $error("ramp step too large");
  shape_sel_a: assert property ((ring_active && !wave_shape_select && $stable(sine_sample) && $stable(ring_offset_enable))[*8] |-> ring_wave_out == sine_sample + (ring_offset_enable ? ring_dc_offset : 16'sh0000))
    else $error("sine path wrong");
  cm_level_a: assert property ((ring_active && $stable(high_battery_setting) && $stable(ring_headroom))[*3] |-> ring_common_mode_level == ((high_battery_setting > 6'(ring_headroom)) ? (high_battery_setting - 6'(ring_headroom)) >> 1 : 6'h00))
    else $error("common mode level wrong");
  pend_set_a: assert property ($rose(trip_detected_status) |-> ##[0:2] trip_irq_pending)
    else $error("pending not set");
  pend_hold_a: assert property (trip_irq_pending && !trip_irq_clear |=> trip_irq_pending)
    else $error("pending lost");
endmodule
`default_nettype wire

// File: dv/rsgtd_line_model.sv
// Far-side line model: external sine source and loop-current sense.
`timescale 1ns/1ps
`default_nettype none
module rsgtd_line_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic off_hook,
  input wire logic signed [15:0] ring_wave_out,
  output logic signed [15:0] sine_sample,
  output logic signed [15:0] loop_current_sample
);
  logic [5:0] tick_q;
  // Each tone value stands 64 clocks so several sample strobes see it.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= '0;
      sine_sample <= 16'sh0100;
    end else begin
      tick_q <= tick_q + 6'h01;
      if (tick_q == 6'h3f) begin
        sine_sample <= -sine_sample;
      end
    end
  end
  // On hook only leakage follows the ring voltage; off hook the loop draws heavily.
  assign loop_current_sample = off_hook ? 16'sh6000 : (ring_wave_out >>> 8);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the ringing shaper and trip detector.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rsgtd_pkg::*;
  logic ref_clk, nrst, off_hook, wave_shape_select, ring_offset_enable, trip_irq_clear;
  logic transition_current_boost_en, ring_on_timer_en, ring_off_timer_en, trip_irq_enable;
  logic ring_active, current_boost, trip_detected_status, trip_irq_pending, trip_irq;
  logic [2:0] line_state_field;
  logic [3:0] ring_headroom;
  logic [5:0] high_battery_setting, ring_common_mode_level, trip_threshold;
  logic [6:0] trip_debounce_interval;
  logic [12:0] trip_filter_coeff;
  logic [15:0] ring_amplitude, ring_phase_or_half_period, ring_freq_or_ramp_step;
  logic [15:0] ring_on_timer, ring_off_timer;
  logic signed [15:0] ring_dc_offset, sine_sample, loop_current_sample, ring_wave_out, hi, lo;
  int err_total, num_checks, seed, cyc, i, n;
  rsgtd_top #(.SAMPLE_DIV_P(4)) dut (.ref_clk, .nrst, .line_state_field, .wave_shape_select,
    .ring_offset_enable, .ring_amplitude, .ring_phase_or_half_period, .ring_freq_or_ramp_step,
    .ring_dc_offset, .sine_sample, .ring_headroom, .high_battery_setting,
    .transition_current_boost_en, .ring_on_timer_en, .ring_off_timer_en, .ring_on_timer,
    .ring_off_timer, .loop_current_sample, .trip_filter_coeff, .trip_threshold,
    .trip_debounce_interval, .trip_irq_enable, .trip_irq_clear, .ring_wave_out, .ring_active,
    .ring_common_mode_level, .current_boost, .trip_detected_status, .trip_irq_pending, .trip_irq);
  rsgtd_line_model far_end (.ref_clk, .nrst, .off_hook, .ring_wave_out, .sine_sample,
    .loop_current_sample);
  initial ref_clk = 1'b0;
  always #10 ref_clk = ~ref_clk;
  task automatic chk_bit(input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t bit exp %b got %b", $time, exp, got);
    end
  endtask
  task automatic chk_val(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t value exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Peak of a clamped trapezoid, shifted by the fixed offset when enabled.
  function automatic logic signed [15:0] trap_peak(input logic [15:0] a, input logic oe,
      input logic neg);
    return (neg ? -$signed(a) : $signed(a)) + (oe ? 16'sh0200 : 16'sh0000);
  endfunction
  function automatic logic [5:0] cm_level(input logic [5:0] b, input logic [3:0] h);
    return (b > 6'(h)) ? (b - 6'(h)) >> 1 : 6'h00;
  endfunction
  // Whole run needs under 2000 cycles; a hang is cut off well beyond that.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    seed = 7;
    {nrst, off_hook, wave_shape_select, ring_offset_enable, trip_irq_clear} = '0;
    {transition_current_boost_en, ring_on_timer_en, ring_off_timer_en, trip_irq_enable} = '0;
    {line_state_field, ring_headroom, high_battery_setting, trip_debounce_interval} = '0;
    {ring_amplitude, ring_phase_or_half_period, ring_freq_or_ramp_step, ring_dc_offset} = '0;
    {ring_on_timer, ring_off_timer} = '0;
    trip_filter_coeff = 13'h1fff;
    trip_threshold = 6'h08;
    cycles(12);
    nrst = 1'b1;
    cycles(2);
    chk_val(16'h0000, ring_wave_out);
    // Random trapezoids; a battery below the headroom comes first as the corner case.
    // Amplitude stays above the offset so the idle zero output lies inside the swing.
    for (i = 0; i < 4; i++) begin
      ring_amplitude = 16'h0300 + 16'($unsigned($random(seed)) % 8192);
      ring_freq_or_ramp_step = (ring_amplitude >> 1) + 16'h0001;
      ring_phase_or_half_period = 16'h0004 + 16'(i);
      {ring_offset_enable, transition_current_boost_en} = {2{i[0]}};
      ring_dc_offset = 16'sh0200;
      high_battery_setting = (i == 0) ? 6'h02 : 6'($random(seed));
      ring_headroom = (i == 0) ? 4'hf : 4'($random(seed));
      wave_shape_select = 1'b1;
      line_state_field = LINE_STATE_RINGING;
      {hi, lo} = '0;
      repeat (200) begin
        cycles(1);
        hi = (ring_wave_out > hi) ? ring_wave_out : hi;
        lo = (ring_wave_out < lo) ? ring_wave_out : lo;
      end
      chk_val(trap_peak(ring_amplitude, ring_offset_enable, 1'b0), hi);
      chk_val(trap_peak(ring_amplitude, ring_offset_enable, 1'b1), lo);
      chk_val(16'(cm_level(high_battery_setting, ring_headroom)), 16'(ring_common_mode_level));
      line_state_field = 3'h0;
      cycles(3);
      chk_bit(i[0], current_boost);
      cycles(70);
    end
    wave_shape_select = 1'b0;
    ring_offset_enable = 1'b1;
    line_state_field = LINE_STATE_RINGING;
    @(sine_sample);
    cycles(12);
    chk_val(sine_sample + ring_dc_offset, ring_wave_out);
    // A two-sample glitch must be debounced away; a held off-hook must trip.
    trip_debounce_interval = 7'h04 + 7'($unsigned($random(seed)) % 3);
    off_hook = 1'b1;
    cycles(8);
    off_hook = 1'b0;
    cycles(60);
    chk_bit(1'b0, trip_detected_status);
    off_hook = 1'b1;
    cycles(60);
    chk_bit(1'b1, trip_detected_status);
    chk_bit(1'b1, trip_irq_pending);
    chk_bit(1'b0, trip_irq);
    trip_irq_enable = 1'b1;
    cycles(1);
    chk_bit(1'b1, trip_irq);
    trip_irq_clear = 1'b1;
    cycles(1);
    trip_irq_clear = 1'b0;
    cycles(1);
    chk_bit(1'b0, trip_irq_pending);
    line_state_field = 3'h0;
    cycles(80);
    chk_bit(1'b0, trip_detected_status);
    chk_bit(1'b0, trip_irq_pending);
    off_hook = 1'b0;
    // Cadence of three samples on and two off; the windows allow a strobe of phase slack.
    {ring_on_timer, ring_off_timer} = {16'h0003, 16'h0002};
    {ring_on_timer_en, ring_off_timer_en} = 2'b11;
    line_state_field = LINE_STATE_RINGING;
    cycles(3);
    for (n = 0; n < 40 && ring_active === 1'b1; n++) begin
      cycles(1);
    end
    chk_bit(1'b1, n >= 4 && n <= 18);
    for (n = 0; n < 40 && ring_active === 1'b0; n++) begin
      cycles(1);
    end
    chk_bit(1'b1, n >= 4 && n <= 14);
    report_and_stop();
  end
endmodule
bind rsgtd_top rsgtd_chk chk (.ref_clk, .nrst, .line_state_field, .wave_shape_select,
  .ring_offset_enable, .ring_amplitude, .ring_freq_or_ramp_step, .ring_dc_offset, .sine_sample,
  .ring_headroom, .high_battery_setting, .trip_irq_clear, .ring_wave_out, .ring_active,
  .ring_common_mode_level, .trip_detected_status, .trip_irq_pending);
`default_nettype wire
